// file: common/scalar_pkg.sv
package scalar_pkg;
   // Data path widths
   localparam int WORD_W = 64;
   localparam int COUNT_W = 24;
   localparam int DESIG_W = 3;
   localparam int OP_W = 7;
   localparam int IMM_W = 6;
   localparam int AMT_W = 7;
   // Opcodes handled by the logical and shift units
   localparam logic [OP_W-1:0] OP_AND = 7'h24;
   localparam logic [OP_W-1:0] OP_AND_NOT = 7'h25;
   localparam logic [OP_W-1:0] OP_XOR = 7'h26;
   localparam logic [OP_W-1:0] OP_EQV = 7'h27;
   localparam logic [OP_W-1:0] OP_MERGE = 7'h28;
   localparam logic [OP_W-1:0] OP_OR = 7'h29;
   localparam logic [OP_W-1:0] OP_SHL_ZERO = 7'h2a;
   localparam logic [OP_W-1:0] OP_SHR_ZERO = 7'h2b;
   localparam logic [OP_W-1:0] OP_SHL_SELF = 7'h2c;
   localparam logic [OP_W-1:0] OP_SHR_SELF = 7'h2d;
   localparam logic [OP_W-1:0] OP_DSHL = 7'h2e;
   localparam logic [OP_W-1:0] OP_DSHR = 7'h2f;
   // Fixed operand values
   localparam logic [WORD_W-1:0] SIGN_BIT_ONLY = 64'h8000_0000_0000_0000;
   localparam logic [WORD_W-1:0] ZERO_WORD = 64'h0;
   localparam logic [DESIG_W-1:0] ZERO_REG = 3'h0;
   localparam logic [AMT_W-1:0] IMM_SPAN = 7'h40;
   localparam int DOUBLE_MAX = 127;
   localparam int DEFAULT_COUNT = 1;
   // Result latencies in clock periods
   localparam int LOGIC_READY_CP = 1;
   localparam int IMM_READY_CP = 2;
   localparam int DBL_READY_CP = 3;

   typedef struct packed {
      logic valid;
      logic [OP_W-1:0] opcode;
      logic [DESIG_W-1:0] i;
      logic [DESIG_W-1:0] j;
      logic [DESIG_W-1:0] k;
   } issue_request_type;

   typedef struct packed {
      logic [WORD_W-1:0] target;
      logic [WORD_W-1:0] first;
      logic [WORD_W-1:0] second;
      logic [COUNT_W-1:0] count;
   } operand_type;

   typedef struct packed {
      logic target;
      logic first;
      logic second;
      logic count;
      logic zero;
   } reserve_type;

   typedef struct packed {
      logic valid;
      logic [DESIG_W-1:0] dest;
      logic [WORD_W-1:0] data;
   } result_type;
endpackage : scalar_pkg

// file: hw/logic_unit.sv
`timescale 1ns/10ps
module logic_unit (
   input wire logic [scalar_pkg::OP_W-1:0] opcode,
   input wire logic j_zero,
   input wire logic k_zero,
   input wire logic [scalar_pkg::WORD_W-1:0] target_register,
   input wire logic [scalar_pkg::WORD_W-1:0] first_in,
   input wire logic [scalar_pkg::WORD_W-1:0] second_in,
   output logic [scalar_pkg::WORD_W-1:0] result
);
   logic [scalar_pkg::WORD_W-1:0] first_operand;
   logic [scalar_pkg::WORD_W-1:0] second_operand;

   // Register 0 reads as zero or sign bit only
   assign first_operand = j_zero ? scalar_pkg::ZERO_WORD : first_in;
   assign second_operand = k_zero ? scalar_pkg::SIGN_BIT_ONLY : second_in;

   // Bitwise operation select
   always_comb begin
      case (opcode)
         scalar_pkg::OP_AND: result = first_operand & second_operand;
         scalar_pkg::OP_AND_NOT: result = first_operand & ~second_operand;
         scalar_pkg::OP_XOR: result = first_operand ^ second_operand;
         scalar_pkg::OP_EQV: result = ~(first_operand ^ second_operand);
         scalar_pkg::OP_MERGE: begin
            result = (first_operand & second_operand)
               | (target_register & ~second_operand);
         end
         scalar_pkg::OP_OR: result = first_operand | second_operand;
         default: result = scalar_pkg::ZERO_WORD;
      endcase
   end
endmodule : logic_unit

// file: hw/shift_unit.sv
`timescale 1ns/10ps
module shift_unit #(
   parameter int COUNT_W = scalar_pkg::COUNT_W
) (
   input wire logic [scalar_pkg::OP_W-1:0] opcode,
   input wire logic [scalar_pkg::DESIG_W-1:0] i_des,
   input wire logic [scalar_pkg::DESIG_W-1:0] j_des,
   input wire logic k_zero,
   input wire logic [scalar_pkg::IMM_W-1:0] immediate_count_field,
   input wire logic [scalar_pkg::WORD_W-1:0] target_register,
   input wire logic [scalar_pkg::WORD_W-1:0] first_in,
   input wire logic [COUNT_W-1:0] count_register,
   output logic [scalar_pkg::WORD_W-1:0] imm_result,
   output logic [scalar_pkg::WORD_W-1:0] dbl_result
);
   localparam int W = scalar_pkg::WORD_W;
   logic [scalar_pkg::AMT_W-1:0] right_amt;
   logic [W-1:0] left_imm;
   logic [W-1:0] right_imm;
   logic [COUNT_W-1:0] count;
   logic count_over;
   logic [W-1:0] partner;
   logic [2*W-1:0] pair_left;
   logic [2*W-1:0] pair_right;

   // Immediate shifts are end off, zero fill; right by 64 clears the word
   assign right_amt = scalar_pkg::IMM_SPAN - scalar_pkg::AMT_W'(immediate_count_field);
   assign left_imm = target_register << immediate_count_field;
   assign right_imm = target_register >> right_amt;
   assign imm_result = opcode[0] ? right_imm : left_imm;

   // Double shift count and partner word
   assign count = k_zero ? COUNT_W'(scalar_pkg::DEFAULT_COUNT) : count_register;
   assign count_over = count > COUNT_W'(scalar_pkg::DOUBLE_MAX);
   assign partner = (j_des == scalar_pkg::ZERO_REG) ? scalar_pkg::ZERO_WORD
      : ((i_des == j_des) ? target_register : first_in);

   // Joined 128-bit shifts; i equal j gives rotation up to 64
   assign pair_left = {target_register, partner} << count[scalar_pkg::AMT_W-1:0];
   assign pair_right = {partner, target_register} >> count[scalar_pkg::AMT_W-1:0];

   // Only the target word is produced; the partner keeps its value
   always_comb begin
      if (count_over) begin
         dbl_result = scalar_pkg::ZERO_WORD;
      end else if (opcode == scalar_pkg::OP_DSHL) begin
         dbl_result = pair_left[2*W-1:W];
      end else begin
         dbl_result = pair_right[W-1:0];
      end
   end
endmodule : shift_unit

// file: hw/scalar_logic_shift_units.sv
`timescale 1ns/10ps
// Operation
// - j zero gives zero, k zero sign bit
// - opcode 044 writes bitwise AND
// - opcode 045 writes first AND NOT second
// - opcode 046 writes exclusive OR
// - opcode 047 writes equivalence, inverse of XOR
// - opcode 050 merges first into target by mask
// - opcode 051 writes inclusive OR
// - logical hold on reservations, ready 1 CP
// - 052/054 shift left by immediate count
// - 053/055 shift right by 64 minus count
// - immediate shifts end off, zero fill
// - hold immediate shifts after double or add
// - immediate shift result ready 2 CPs
// - double shift uses full 24-bit count
// - k zero means count of one
// - j zero uses zero partner word
// - i equals j nonzero rotates up to 64
// - over 64 end off; partner kept
// - i equals j over 64 as single shift
// - 056 left pair, upper half, clear over 127
// - 057 right pair, lower half, clear over 127
// - double shift hold on reservations, ready 3 CPs
module scalar_logic_shift_units #(
   parameter int COUNT_W = scalar_pkg::COUNT_W
) (
   input wire logic clk,
   input wire logic resetn,
   input wire scalar_pkg::issue_request_type issue_req,
   input wire logic [scalar_pkg::IMM_W-1:0] immediate_count_field,
   input wire scalar_pkg::operand_type operands,
   input wire scalar_pkg::reserve_type reserved,
   input wire logic add_issued_prev,
   output logic issue_taken,
   output logic issue_refused,
   output scalar_pkg::result_type logical_result,
   output scalar_pkg::result_type shift_result
);
   // Count must be able to express counts above 127
   if (COUNT_W < scalar_pkg::AMT_W + 1 || COUNT_W > scalar_pkg::COUNT_W) begin : g_count_check
      $error("COUNT_W too narrow for double shift counts");
   end

   // Opcode range decode
   function automatic logic op_in(input logic [scalar_pkg::OP_W-1:0] op,
                                  input logic [scalar_pkg::OP_W-1:0] lo,
                                  input logic [scalar_pkg::OP_W-1:0] hi);
      op_in = (op >= lo) && (op <= hi);
   endfunction : op_in

   logic is_logical;
   logic is_imm;
   logic is_dbl;
   logic to_zero_reg;
   logic j_zero;
   logic k_zero;
   logic first_busy;
   logic hold_logical;
   logic hold_imm;
   logic hold_dbl;
   logic take_logical;
   logic take_imm;
   logic take_dbl;
   logic take_any;
   logic [scalar_pkg::WORD_W-1:0] logic_value;
   logic [scalar_pkg::WORD_W-1:0] imm_value;
   logic [scalar_pkg::WORD_W-1:0] dbl_value;
   logic [scalar_pkg::DESIG_W-1:0] imm_dest;

   logic issue_taken_reg;
   logic issue_refused_reg;
   logic dbl_prev_reg;
   scalar_pkg::result_type logical_result_reg;
   scalar_pkg::result_type logical_result_next;
   scalar_pkg::result_type imm_stage_reg;
   scalar_pkg::result_type imm_stage_next;
   scalar_pkg::result_type dbl_stage1_reg;
   scalar_pkg::result_type dbl_stage1_next;
   scalar_pkg::result_type dbl_stage2_reg;
   scalar_pkg::result_type shift_result_reg;
   scalar_pkg::result_type shift_result_next;

   // Functional unit selection
   assign is_logical = op_in(issue_req.opcode, scalar_pkg::OP_AND, scalar_pkg::OP_OR);
   assign is_imm = op_in(issue_req.opcode, scalar_pkg::OP_SHL_ZERO,
                         scalar_pkg::OP_SHR_SELF);
   assign is_dbl = op_in(issue_req.opcode, scalar_pkg::OP_DSHL, scalar_pkg::OP_DSHR);
   assign to_zero_reg = op_in(issue_req.opcode, scalar_pkg::OP_SHL_ZERO,
                              scalar_pkg::OP_SHR_ZERO);
   assign j_zero = issue_req.j == scalar_pkg::ZERO_REG;
   assign k_zero = issue_req.k == scalar_pkg::ZERO_REG;

   // Hold conditions; register 0 never blocks as a source
   assign first_busy = reserved.first && !j_zero;
   assign hold_logical = reserved.target || first_busy
      || (reserved.second && !k_zero);
   assign hold_imm = dbl_prev_reg || add_issued_prev || reserved.target
      || (to_zero_reg && reserved.zero);
   assign hold_dbl = reserved.target || first_busy
      || (reserved.count && !k_zero);

   // Issue decisions
   assign take_logical = issue_req.valid && is_logical && !hold_logical;
   assign take_imm = issue_req.valid && is_imm && !hold_imm;
   assign take_dbl = issue_req.valid && is_dbl && !hold_dbl;
   assign take_any = take_logical || take_imm || take_dbl;

   logic_unit u_logic (
      .opcode(issue_req.opcode),
      .j_zero(j_zero),
      .k_zero(k_zero),
      .target_register(operands.target),
      .first_in(operands.first),
      .second_in(operands.second),
      .result(logic_value)
   );

   shift_unit #(
      .COUNT_W(COUNT_W)
   ) u_shift (
      .opcode(issue_req.opcode),
      .i_des(issue_req.i),
      .j_des(issue_req.j),
      .k_zero(k_zero),
      .immediate_count_field(immediate_count_field),
      .target_register(operands.target),
      .first_in(operands.first),
      .count_register(operands.count[COUNT_W-1:0]),
      .imm_result(imm_value),
      .dbl_result(dbl_value)
   );

   // Immediate shifts of 052 and 053 land in register 0
   assign imm_dest = to_zero_reg ? scalar_pkg::ZERO_REG : issue_req.i;

   // Stage contents on issue
   assign logical_result_next = '{valid: take_logical, dest: issue_req.i,
                                  data: logic_value};
   assign imm_stage_next = '{valid: take_imm, dest: imm_dest, data: imm_value};
   assign dbl_stage1_next = '{valid: take_dbl, dest: issue_req.i,
                              data: dbl_value};

   // Shared shift result path; hold on prior double keeps slots apart
   assign shift_result_next = imm_stage_reg.valid ? imm_stage_reg : dbl_stage2_reg;

   // Issue answer and double-issue history
   always_ff @(posedge clk) begin
      if (!resetn) begin
         issue_taken_reg <= 1'b0;
         issue_refused_reg <= 1'b0;
         dbl_prev_reg <= 1'b0;
      end else begin
         issue_taken_reg <= take_any;
         issue_refused_reg <= issue_req.valid && !take_any;
         dbl_prev_reg <= take_dbl;
      end
   end

   // Logical result, one period after issue
   always_ff @(posedge clk) begin
      if (!resetn) begin
         logical_result_reg <= '0;
      end else begin
         logical_result_reg <= logical_result_next;
      end
   end

   // Shift pipeline: immediate two periods, double three
   always_ff @(posedge clk) begin
      if (!resetn) begin
         imm_stage_reg <= '0;
         dbl_stage1_reg <= '0;
         dbl_stage2_reg <= '0;
         shift_result_reg <= '0;
      end else begin
         imm_stage_reg <= imm_stage_next;
         dbl_stage1_reg <= dbl_stage1_next;
         dbl_stage2_reg <= dbl_stage1_reg;
         shift_result_reg <= shift_result_next;
      end
   end

   assign issue_taken = issue_taken_reg;
   assign issue_refused = issue_refused_reg;
   assign logical_result = logical_result_reg;
   assign shift_result = shift_result_reg;

   // Checks on issue timing and results
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   sequence s_dbl_issue;
      take_dbl;
   endsequence

   sequence s_imm_after_dbl;
      s_dbl_issue ##1 (issue_req.valid && is_imm);
   endsequence

   sequence s_imm_issue;
      take_imm;
   endsequence

   // Immediate result walks one stage, then reaches the port
   sequence s_imm_path;
      imm_stage_reg.valid ##1 shift_result.valid;
   endsequence

   // Double result walks two stages, then reaches the port
   sequence s_dbl_path;
      dbl_stage1_reg.valid ##1 dbl_stage2_reg.valid ##1 shift_result.valid;
   endsequence

   AST_LOGIC_READY: assert property (
      take_logical |=> (logical_result.valid && logical_result.dest == $past(issue_req.i))
         ##1 !logical_result.valid || $past(take_logical))
      else $error("logical result not ready one period after issue");

   AST_LOGIC_HOLD: assert property (
      (issue_req.valid && is_logical && reserved.target) |=> !issue_taken && issue_refused)
      else $error("logical issue not held on reserved target");

   AST_AND_VALUE: assert property (
      (take_logical && issue_req.opcode == scalar_pkg::OP_AND && !j_zero && !k_zero)
         |=> logical_result.data == ($past(operands.first) & $past(operands.second)))
      else $error("AND result wrong");

   AST_OR_SIGN_ONLY: assert property (
      (take_logical && issue_req.opcode == scalar_pkg::OP_OR && j_zero && k_zero)
         |=> logical_result.data == scalar_pkg::SIGN_BIT_ONLY)
      else $error("OR of register 0 pair not sign bit only");

   AST_IMM_READY: assert property (
      s_imm_issue |=> s_imm_path)
      else $error("immediate shift result not ready two periods after issue");

   AST_IMM_TO_ZERO: assert property (
      (take_imm && to_zero_reg) |-> ##2 shift_result.dest == scalar_pkg::ZERO_REG)
      else $error("052/053 result not sent to register 0");

   AST_RIGHT_64_CLEARS: assert property (
      (take_imm && issue_req.opcode[0] && immediate_count_field == '0)
         |-> ##2 shift_result.data == scalar_pkg::ZERO_WORD)
      else $error("right shift by 64 did not clear");

   AST_IMM_HOLD_AFTER_DBL: assert property (
      s_imm_after_dbl |=> issue_refused)
      else $error("immediate shift issued right after double shift");

   AST_DBL_READY: assert property (
      s_dbl_issue |=> s_dbl_path)
      else $error("double shift result not ready three periods after issue");

   AST_DBL_OVER_CLEARS: assert property (
      (take_dbl && !k_zero && operands.count > COUNT_W'(scalar_pkg::DOUBLE_MAX))
         |-> ##3 shift_result.data == scalar_pkg::ZERO_WORD)
      else $error("double shift over 127 did not clear");

   AST_DBL_COUNT_HOLD: assert property (
      (issue_req.valid && is_dbl && !k_zero && reserved.count) |=> !issue_taken)
      else $error("double shift not held on reserved count register");
endmodule : scalar_logic_shift_units

// file: tb/reg_file_model.sv
`timescale 1ns/10ps
// Issue side: scalar and count registers feeding the units, results written back
module reg_file_model (
   input wire logic clk,
   input wire scalar_pkg::issue_request_type issue_req,
   input wire scalar_pkg::result_type logical_result,
   input wire scalar_pkg::result_type shift_result,
   output scalar_pkg::operand_type operands
);
   logic [63:0] s_reg [8];
   logic [23:0] a_reg [8];

   // Registers read by designator in the request cycle
   assign operands = '{s_reg[issue_req.i], s_reg[issue_req.j], s_reg[issue_req.k],
                       a_reg[issue_req.k]};

   // Results are written to the register file at the clock edge after the cycle they are reported
   always @(posedge clk) begin
      if (logical_result.valid) begin
         s_reg[logical_result.dest] <= logical_result.data;
      end
      if (shift_result.valid) begin
         s_reg[shift_result.dest] <= shift_result.data;
      end
   end
endmodule : reg_file_model

// file: tb/scalar_logic_shift_units_test.sv
`timescale 1ns/10ps
// Self-checking bench for the scalar logical and shift units
module scalar_logic_shift_units_test;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   scalar_pkg::issue_request_type req = '0;
   logic [5:0] imm = 6'h0;
   scalar_pkg::reserve_type rsv = '0;
   logic add_prev = 1'b0;
   scalar_pkg::operand_type opnd;
   scalar_pkg::result_type lres;
   scalar_pkg::result_type sres;
   logic taken;
   logic refused;
   logic [63:0] s [8];
   logic [23:0] a [8];
   logic [63:0] rnd = 64'h5f;
   logic [63:0] e;
   int miscompares = 0;
   int num_checks = 0;

   scalar_logic_shift_units uut (.clk(clk), .resetn(resetn), .issue_req(req),
      .immediate_count_field(imm), .operands(opnd), .reserved(rsv),
      .add_issued_prev(add_prev), .issue_taken(taken), .issue_refused(refused),
      .logical_result(lres), .shift_result(sres));
   reg_file_model rf (.clk(clk), .issue_req(req), .logical_result(lres),
      .shift_result(sres), .operands(opnd));

   // Clock of 100 ns period
   initial begin
      forever #50 clk = ~clk;
   end

   // Next value of the pseudo-random sequence
   function automatic logic [63:0] step(input logic [63:0] v);
      return {v[62:0], v[63] ^ v[62] ^ v[60] ^ v[59]};
   endfunction : step

   // Expected result from the mirrored registers
   function automatic logic [63:0] model(input logic [6:0] op, input logic [2:0] i, j, k,
                                         input logic [5:0] jk);
      logic [63:0] x;
      logic [63:0] y;
      logic [23:0] n;
      logic [127:0] w;
      x = (j == 3'h0) ? 64'h0 : s[j];
      y = (k == 3'h0) ? scalar_pkg::SIGN_BIT_ONLY : s[k];
      n = (k == 3'h0) ? 24'h1 : a[k];
      case (op)
         7'h24: return x & y;
         7'h25: return x & ~y;
         7'h26: return x ^ y;
         7'h27: return ~(x ^ y);
         7'h28: return (x & y) | (s[i] & ~y);
         7'h29: return x | y;
         7'h2a, 7'h2c: return s[i] << jk;
         7'h2b, 7'h2d: return s[i] >> (7'h40 - {1'b0, jk});
         7'h2e: begin
            w = {s[i], x} << n;
            return w[127:64];
         end
         7'h2f: begin
            w = {x, s[i]} >> n;
            return w[63:0];
         end
         default: return 64'h0;
      endcase
   endfunction : model

   // Compare one value and count the outcome
   task automatic chk(input string name, input logic [63:0] ex, input logic [63:0] g);
      num_checks++;
      if (g !== ex) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, ex, g);
      end
   endtask : chk

   // Set a register pair in the register file model and in the mirror
   task automatic load(input logic [2:0] x, input logic [63:0] sv, input logic [23:0] av);
      s[x] = sv;
      a[x] = av;
      rf.s_reg[x] = sv;
      rf.a_reg[x] = av;
   endtask : load

   // Change reservations and the add flag at a clock edge
   task automatic hold(input logic [4:0] r, input logic ad);
      @(posedge clk);
      rsv <= r;
      add_prev <= ad;
   endtask : hold

   // One request, its answer and its result at the fixed latency
   task automatic run(input logic [6:0] op, input logic [2:0] i, j, k, input logic [5:0] jk,
                      input logic ok);
      int lat;
      logic [2:0] d;
      scalar_pkg::result_type r;
      e = model(op, i, j, k, jk);
      lat = (op < 7'h2a) ? 1 : ((op < 7'h2e) ? 2 : 3);
      d = (op == 7'h2a || op == 7'h2b) ? 3'h0 : i;
      @(posedge clk);
      req <= '{1'b1, op, i, j, k};
      imm <= jk;
      @(posedge clk);
      req.valid <= 1'b0;
      #1;
      chk("issue_taken", {63'h0, ok}, {63'h0, taken});
      chk("issue_refused", {63'h0, ~ok}, {63'h0, refused});
      repeat (lat - 1) @(posedge clk);
      #1;
      r = (lat == 1) ? lres : sres;
      chk("result_valid", {63'h0, ok}, {63'h0, r.valid});
      if (ok) begin
         chk("result_dest", {61'h0, d}, {61'h0, r.dest});
         chk("result_data", e, r.data);
         s[d] = e;
      end
      // Let the write-back land before any later register load
      @(posedge clk);
      #1;
   endtask : run

   // Final counts and verdict
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      stop_test();
   end

   // Main sequence
   initial begin
      for (int x = 0; x < 8; x++) begin
         rnd = step(rnd);
         load(x[2:0], rnd, rnd[30:7]);
      end
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      #1;
      chk("reset_idle", 64'h0, {60'h0, lres.valid, sres.valid, taken, refused});
      run(7'h24, 3'h3, 3'h5, 3'h5, 6'h0, 1'b1);
      run(7'h24, 3'h3, 3'h0, 3'h2, 6'h0, 1'b1);
      run(7'h25, 3'h4, 3'h6, 3'h6, 6'h0, 1'b1);
      run(7'h26, 3'h1, 3'h2, 3'h0, 6'h0, 1'b1);
      run(7'h27, 3'h1, 3'h0, 3'h0, 6'h0, 1'b1);
      run(7'h28, 3'h2, 3'h3, 3'h4, 6'h0, 1'b1);
      run(7'h28, 3'h2, 3'h0, 3'h0, 6'h0, 1'b1);
      run(7'h29, 3'h5, 3'h0, 3'h0, 6'h0, 1'b1);
      run(7'h30, 3'h1, 3'h2, 3'h3, 6'h0, 1'b0);
      run(7'h23, 3'h1, 3'h2, 3'h3, 6'h0, 1'b0);
      $display("logical tests done");
      run(7'h2a, 3'h3, 3'h7, 3'h7, 6'h3f, 1'b1);
      run(7'h2b, 3'h4, 3'h0, 3'h0, 6'h00, 1'b1);
      run(7'h2c, 3'h6, 3'h0, 3'h1, 6'h00, 1'b1);
      run(7'h2d, 3'h2, 3'h0, 3'h0, 6'h01, 1'b1);
      load(3'h2, s[2], 24'h40);
      run(7'h2e, 3'h5, 3'h5, 3'h2, 6'h0, 1'b1);
      load(3'h3, s[3], 24'h46);
      run(7'h2f, 3'h6, 3'h6, 3'h3, 6'h0, 1'b1);
      load(3'h4, s[4], 24'h80);
      run(7'h2f, 3'h1, 3'h7, 3'h4, 6'h0, 1'b1);
      load(3'h4, s[4], 24'h100040);
      run(7'h2e, 3'h1, 3'h7, 3'h4, 6'h0, 1'b1);
      run(7'h2e, 3'h7, 3'h1, 3'h0, 6'h0, 1'b1);
      chk("partner_kept", s[1], rf.s_reg[1]);
      load(3'h3, s[3], 24'h3f);
      run(7'h2e, 3'h2, 3'h0, 3'h3, 6'h0, 1'b1);
      $display("shift tests done");
      hold(5'b10000, 1'b0);
      run(7'h24, 3'h1, 3'h2, 3'h3, 6'h0, 1'b0);
      hold(5'b01000, 1'b0);
      run(7'h24, 3'h1, 3'h0, 3'h3, 6'h0, 1'b1);
      run(7'h2f, 3'h1, 3'h2, 3'h3, 6'h0, 1'b0);
      hold(5'b00100, 1'b0);
      run(7'h29, 3'h1, 3'h2, 3'h3, 6'h0, 1'b0);
      hold(5'b00010, 1'b0);
      run(7'h2e, 3'h1, 3'h2, 3'h3, 6'h0, 1'b0);
      run(7'h2e, 3'h1, 3'h2, 3'h0, 6'h0, 1'b1);
      hold(5'b00001, 1'b0);
      run(7'h2a, 3'h1, 3'h0, 3'h0, 6'h4, 1'b0);
      run(7'h2c, 3'h1, 3'h0, 3'h0, 6'h4, 1'b1);
      hold(5'b00000, 1'b1);
      run(7'h2d, 3'h1, 3'h0, 3'h0, 6'h4, 1'b0);
      hold(5'b00000, 1'b0);
      // Immediate shift straight after a double shift
      e = model(7'h2e, 3'h1, 3'h2, 3'h0, 6'h0);
      @(posedge clk);
      req <= '{1'b1, 7'h2e, 3'h1, 3'h2, 3'h0};
      @(posedge clk);
      req <= '{1'b1, 7'h2c, 3'h3, 3'h0, 3'h0};
      @(posedge clk);
      req.valid <= 1'b0;
      #1;
      chk("refused_after_double", 64'h1, {63'h0, refused});
      @(posedge clk);
      #1;
      chk("double_data", e, sres.data);
      s[1] = e;
      @(posedge clk);
      #1;
      $display("hold tests done");
      for (int n = 0; n < 60; n++) begin
         rnd = step(rnd);
         if (rnd[0]) begin
            load(rnd[3:1], rnd ^ step(rnd), rnd[4] ? {17'h0, rnd[11:5]} : rnd[40:17]);
         end
         run(7'h24 + {3'h0, rnd[47:44] % 4'hc}, rnd[50:48], rnd[53:51], rnd[56:54],
             rnd[62:57], 1'b1);
      end
      $display("random tests done");
      stop_test();
   end
endmodule : scalar_logic_shift_units_test
